/* File: verilog/qcmp_map.svh */
/*
  Constants of the command port: command fields, register addresses,
  reset values, timing. Assumes a 40 MHz reference clock.
*/
`ifndef QCMP_MAP_SVH
`define QCMP_MAP_SVH
`define QCMP_RW_BIT        7
`define QCMP_CT_HI         6
`define QCMP_CT_LO         5
`define QCMP_CT_LOCAL      2'h0
`define QCMP_CT_GLOBAL     2'h1
`define QCMP_CT_RSVD       2'h2
`define QCMP_CT_RAM        2'h3
`define QCMP_GA_VERSION    5'h00
`define QCMP_GA_INTCLR     5'h01
`define QCMP_GA_SWRST      5'h02
`define QCMP_GA_HWRST      5'h03
`define QCMP_GA_CHOP       5'h04
`define QCMP_GA_CLKCH      5'h05
`define QCMP_GA_FMT        5'h06
`define QCMP_LA_COEFSEL    5'h00
`define QCMP_LA_LOOPIRQ    5'h01
`define QCMP_LA_TXSLOT     5'h04
`define QCMP_LA_RXSLOT     5'h05
`define QCMP_VERSION_VAL   8'h01
`define QCMP_CLKCH_RST     8'h02
`define QCMP_COEFSEL_RST   8'h08
`define QCMP_ZERO8         8'h00
`define QCMP_WORD_TOP      3'h7
`define QCMP_WORD_BOT      3'h0
`define QCMP_BLK_TONE      3'h2
`define QCMP_TONE_WORD_MIN 3'h4
`define QCMP_CE_LSB        4
`define QCMP_NBLK          5
`define QCMP_NCH           4
`define QCMP_RST_MIN_NS    50000
`define QCMP_CLK_PERIOD_NS 25
`endif

/* File: verilog/qcmp_pkg.sv */
/*
  Types of the command port. Uses no macro from qcmp_map.svh.
*/
package qcmp_pkg;
  typedef enum logic [2:0] {
    QCMP_IDLE = 3'h0,
    QCMP_DATA = 3'h1,
    QCMP_DONE = 3'h3
  } qcmp_state_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } qcmp_byte_t;

  typedef struct packed {
    logic [3:0] ch_en;
    logic [3:0] clk_sel;
    logic       a_law;
    logic [3:0] power_up;
    logic       loop_en;
    logic [3:0] sb_dir_out;
    logic       debounce_en;
    logic       irq_en;
    logic       features_en;
    logic [1:0] chop_clk;
    logic       filters_en;
    logic       hpf_en;
  } qcmp_ctrl_t;
endpackage

/* File: verilog/qcmp_cmd_port.sv */
/*
  Command interpreter of a four-channel codec control port: takes
  deserialised bytes framed by chip select, decodes register and
  coefficient RAM accesses and produces read bytes.
  Assumes the serial shifter sits outside on the same clock and hands
  over whole bytes; chip select and reset pin are raw pins.
*/
`timescale 1ns/1ps
`include "qcmp_map.svh"
// Function
// R1 - Command byte: rw, type, five-bit address
// R2 - One to four registers, highest address first
// R3 - RAM word two bytes, MSB first
// R4 - Channel enable command plus select data byte
// R5 - Local read 00001 returns two registers
// R6 - Identification byte precedes every read data
// R7 - Global address 00000 is version register
// R8 - RAM write block 1 fills block 1
// R9 - RAM words stepped from eight down one
// R10 - Block transfer is sixteen bytes
// R11 - Chip select rise aborts, keeps done words
// R12 - Shared blocks global, tone words per channel
// R13 - Host stops after word 5 keeping gain
// R14 - RAM read returns ID plus sixteen bytes
// R15 - Address 00010 selects block three
// R16 - Host resets, then clocks, then programs
// R17 - Default state on pin or command reset
// R18 - Channels down, loopbacks and cutoff off
// R19 - First PCM pins, slots zero to three
// R20 - Default clock selection and A-law
// R21 - Rate equals bit clock, default edges
// R22 - Programmable filters off, high-pass on
// R23 - Signalling pins inputs, no debounce
// R24 - Interrupts, features off, choppers high
// R25 - Resets never touch coefficient RAM
// R26 - Extra bytes ignored until chip select high
module qcmp_cmd_port #(
  parameter int RST_MIN_CYC =
    (`QCMP_RST_MIN_NS + `QCMP_CLK_PERIOD_NS - 1) / `QCMP_CLK_PERIOD_NS,
  parameter logic [7:0] ID_CODE = 8'h5_A  // Arbitrary value
) (
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_ce,
  input  wire logic               i_pin_reset_n,
  input  wire logic               i_cs_n,
  input  wire qcmp_pkg::qcmp_byte_t i_rx,
  input  wire logic               i_tx_ready,
  output logic                    o_tx_valid,
  output logic [7:0]              o_tx_data,
  output qcmp_pkg::qcmp_ctrl_t    o_ctrl,
  output logic [7:0]              o_tx_slot [`QCMP_NCH],
  output logic [7:0]              o_rx_slot [`QCMP_NCH],
  output logic [7:0]              o_coef_sel [`QCMP_NCH],
  output logic [7:0]              o_loop_irq [`QCMP_NCH],
  output logic                    o_tx_pin_one_sel,
  output logic                    o_rx_pin_one_sel,
  output logic                    o_int_clear
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]            cs_sync;
    logic [1:0]            rp_sync;
    logic [15:0]           rst_cnt;
    qcmp_pkg::qcmp_state_t st;
    logic                  rd;
    logic [1:0]            ct;
    logic [4:0]            addr;
    logic [2:0]            word;
    logic                  lowb;
    logic [7:0]            hib;
    logic                  id_pend;
    logic                  txv;
    logic [7:0]            txd;
    logic                  intclr;
    qcmp_pkg::qcmp_ctrl_t  ctrl;
    logic [7:0]            chop;
    logic [7:0]            fmt;
    logic [`QCMP_NCH-1:0][7:0] coef;
    logic [`QCMP_NCH-1:0][7:0] lpirq;
    logic [`QCMP_NCH-1:0][7:0] tslot;
    logic [`QCMP_NCH-1:0][7:0] rslot;
  } qcmp_regs_t;

  qcmp_regs_t q, d;
  // Coefficient RAM kept apart: no reset may reach it
  logic [15:0] ram_q [`QCMP_NBLK*8 + 3*`QCMP_NCH*4];
  logic        ram_we;
  logic [6:0]  ram_ix;
  logic [15:0] ram_wd;

  logic cs_n;
  logic pin_rst;
  logic soft_rst;
  logic byte_in;
  logic [2:0] blk;
  logic [6:0] rd_ix;
  logic [7:0] rd_byte;
  logic [1:0] ch_ix;

  assign cs_n    = q.cs_sync[1];
  assign pin_rst = (q.rst_cnt >= 16'(RST_MIN_CYC));
  assign byte_in = i_rx.valid && !cs_n;
  // Addresses past the last block fall onto the last block
  assign blk     = (q.addr < 5'(`QCMP_NBLK)) ? q.addr[2:0] : 3'h4; // R15

  // ---------------------------------------------------------------
  // Channel and RAM index
  // ---------------------------------------------------------------
  always_comb begin
    ch_ix = 2'h0;
    for (int c = `QCMP_NCH - 1; c >= 0; c--) begin
      if (q.ctrl.ch_en[c]) begin
        ch_ix = 2'(c);
      end
    end
  end

  function automatic logic [6:0] f_ix(input logic [2:0] b,
                                      input logic [2:0] w,
                                      input logic [1:0] c);
    // Tone words live per channel past the shared blocks
    if (b == `QCMP_BLK_TONE && w >= `QCMP_TONE_WORD_MIN) begin // R12
      f_ix = 7'(`QCMP_NBLK*8) + {2'h0, c, 3'(w - 3'h4)};
    end else begin
      f_ix = {1'b0, b, w};
    end
  endfunction

  assign rd_ix = f_ix(blk, q.word, ch_ix); // R15

  // ---------------------------------------------------------------
  // Read data mux
  // ---------------------------------------------------------------
  always_comb begin
    rd_byte = `QCMP_ZERO8;
    if (q.ct == `QCMP_CT_RAM) begin
      rd_byte = q.lowb ? ram_q[rd_ix][7:0] : ram_q[rd_ix][15:8]; // R3 R14
    end else if (q.ct == `QCMP_CT_GLOBAL) begin
      case (q.addr)
        `QCMP_GA_VERSION: rd_byte = `QCMP_VERSION_VAL; // R7
        `QCMP_GA_CHOP:    rd_byte = q.chop;
        `QCMP_GA_CLKCH:   rd_byte = {q.ctrl.ch_en, q.ctrl.clk_sel};
        `QCMP_GA_FMT:     rd_byte = q.fmt;
        default:          rd_byte = `QCMP_ZERO8;
      endcase
    end else begin
      case (q.addr)
        `QCMP_LA_COEFSEL: rd_byte = q.coef[ch_ix];
        `QCMP_LA_LOOPIRQ: rd_byte = q.lpirq[ch_ix]; // R5
        `QCMP_LA_TXSLOT:  rd_byte = q.tslot[ch_ix];
        `QCMP_LA_RXSLOT:  rd_byte = q.rslot[ch_ix];
        default:          rd_byte = `QCMP_ZERO8;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    d        = q;
    ram_we   = 1'b0;
    ram_ix   = rd_ix;
    ram_wd   = {q.hib, i_rx.data[7:2], 2'h0}; // R3
    soft_rst = 1'b0;
    d.cs_sync = {q.cs_sync[0], i_cs_n};
    d.rp_sync = {q.rp_sync[0], i_pin_reset_n};
    d.intclr  = 1'b0;
    if (!q.rp_sync[1]) begin
      if (!pin_rst) begin
        d.rst_cnt = q.rst_cnt + 16'h0001;
      end
    end else begin
      d.rst_cnt = 16'h0000;
    end
    if (q.txv && i_tx_ready) begin
      d.txv = 1'b0;
    end
    if (cs_n) begin
      d.st      = qcmp_pkg::QCMP_IDLE; // R11
      d.id_pend = 1'b0;
    end else begin
      case (q.st)
        qcmp_pkg::QCMP_IDLE: begin
          if (i_rx.valid && i_rx.data[`QCMP_CT_HI:`QCMP_CT_LO]
              != `QCMP_CT_RSVD) begin
            d.rd   = !i_rx.data[`QCMP_RW_BIT]; // R1
            d.ct   = i_rx.data[`QCMP_CT_HI:`QCMP_CT_LO];
            d.addr = i_rx.data[4:0];
            d.lowb = 1'b0;
            d.word = `QCMP_WORD_TOP; // R9
            d.st   = qcmp_pkg::QCMP_DATA;
            d.id_pend = !i_rx.data[`QCMP_RW_BIT]; // R6
            if (i_rx.data[`QCMP_CT_HI:`QCMP_CT_LO] == `QCMP_CT_GLOBAL &&
                i_rx.data[`QCMP_RW_BIT]) begin
              if (i_rx.data[4:0] == `QCMP_GA_SWRST ||
                  i_rx.data[4:0] == `QCMP_GA_HWRST) begin
                soft_rst = 1'b1; // R17
              end
              if (i_rx.data[4:0] == `QCMP_GA_INTCLR) begin
                d.intclr = 1'b1;
              end
            end
          end
        end
        qcmp_pkg::QCMP_DATA: begin
          if (q.rd && !q.txv) begin
            if (q.id_pend) begin
              d.txv = 1'b1;
              d.txd = ID_CODE; // R6
              d.id_pend = 1'b0;
            end else begin
              d.txv = 1'b1;
              d.txd = rd_byte;
            end
          end
          if ((q.rd && !q.txv && !q.id_pend) || (!q.rd && byte_in)) begin
            if (!q.rd && q.ct == `QCMP_CT_RAM) begin
              if (!q.lowb) begin
                d.hib = i_rx.data; // R3
              end else begin
                ram_we = 1'b1; // R8
              end
            end else if (!q.rd && q.ct == `QCMP_CT_GLOBAL) begin
              case (q.addr)
                `QCMP_GA_CLKCH: begin
                  d.ctrl.ch_en   = i_rx.data[7:`QCMP_CE_LSB]; // R4
                  d.ctrl.clk_sel = i_rx.data[3:0];
                end
                `QCMP_GA_CHOP: d.chop = i_rx.data;
                `QCMP_GA_FMT: begin
                  d.fmt = i_rx.data;
                  d.ctrl.a_law = !i_rx.data[7];
                end
                default: d.fmt = q.fmt; // Version write is no-op
              endcase
            end else if (!q.rd) begin
              for (int c = 0; c < `QCMP_NCH; c++) begin
                if (q.ctrl.ch_en[c]) begin
                  case (q.addr)
                    `QCMP_LA_COEFSEL: d.coef[c]  = i_rx.data;
                    `QCMP_LA_LOOPIRQ: d.lpirq[c] = i_rx.data;
                    `QCMP_LA_TXSLOT:  d.tslot[c] = i_rx.data;
                    `QCMP_LA_RXSLOT:  d.rslot[c] = i_rx.data;
                    default:          d.coef[c]  = q.coef[c];
                  endcase
                end
              end
            end
            if (q.ct == `QCMP_CT_RAM) begin
              d.lowb = !q.lowb;
              if (q.lowb) begin
                d.word = q.word - 3'h1; // R10
                if (q.word == `QCMP_WORD_BOT) begin
                  d.st = qcmp_pkg::QCMP_DONE;
                end
              end
            end else begin
              d.addr = q.addr - 5'h01; // R2
              if (q.addr[1:0] == 2'h0) begin
                d.st = qcmp_pkg::QCMP_DONE;
              end
            end
          end
        end
        qcmp_pkg::QCMP_DONE: d.st = qcmp_pkg::QCMP_DONE; // R26
        default: d.st = qcmp_pkg::QCMP_IDLE;
      endcase
    end
    if (soft_rst || pin_rst) begin
      d.st    = qcmp_pkg::QCMP_IDLE; // R17
      d.txv   = 1'b0;
      d.ctrl  = '0; // R18 R22 R23 R24
      d.ctrl.clk_sel  = 4'(`QCMP_CLKCH_RST); // R20
      d.ctrl.a_law    = 1'b1;
      d.ctrl.chop_clk = 2'h3; // R24
      d.ctrl.hpf_en   = 1'b1; // R22
      d.chop = `QCMP_ZERO8;
      d.fmt  = `QCMP_ZERO8; // R21
      d.intclr = 1'b1; // R24
      for (int c = 0; c < `QCMP_NCH; c++) begin
        d.coef[c]  = `QCMP_COEFSEL_RST;
        d.lpirq[c] = `QCMP_ZERO8;
        d.tslot[c] = 8'(c); // R19
        d.rslot[c] = 8'(c);
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      q <= '0;
      q.cs_sync <= 2'h3;
      q.rp_sync <= 2'h3;
      q.ctrl.clk_sel  <= 4'(`QCMP_CLKCH_RST);
      q.ctrl.a_law    <= 1'b1;
      q.ctrl.chop_clk <= 2'h3;
      q.ctrl.hpf_en   <= 1'b1;
      q.coef  <= {`QCMP_NCH{`QCMP_COEFSEL_RST}};
      q.tslot <= {8'h03, 8'h02, 8'h01, 8'h00};
      q.rslot <= {8'h03, 8'h02, 8'h01, 8'h00};
    end else if (i_ce) begin
      q <= d;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_ce && ram_we) begin
      ram_q[ram_ix] <= ram_wd; // R25
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_tx_valid = q.txv;
  assign o_tx_data  = q.txd;
  assign o_ctrl     = q.ctrl;
  assign o_int_clear = q.intclr;
  assign o_tx_pin_one_sel = !q.tslot[0][7]; // R19
  assign o_rx_pin_one_sel = !q.rslot[0][7];
  for (genvar g = 0; g < `QCMP_NCH; g++) begin : g_ch
    assign o_tx_slot[g]  = q.tslot[g];
    assign o_rx_slot[g]  = q.rslot[g];
    assign o_coef_sel[g] = q.coef[g];
    assign o_loop_irq[g] = q.lpirq[g];
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_cmd_rd;
    !cs_n && q.st == qcmp_pkg::QCMP_IDLE && i_rx.valid &&
    !i_rx.data[7] && i_rx.data[6:5] != `QCMP_CT_RSVD;
  endsequence
  property p_id_first;
    @(posedge i_ref_clk) disable iff (!i_rst_n || !i_ce)
    s_cmd_rd ##1 !cs_n ##1 !cs_n |=> (o_tx_valid && o_tx_data == ID_CODE);
  endproperty
  a_id_first: assert property (p_id_first) else $error("no id"); // R6
  property p_abort;
    @(posedge i_ref_clk) disable iff (!i_rst_n || !i_ce)
    cs_n |=> q.st == qcmp_pkg::QCMP_IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort"); // R11
  property p_rst_defaults;
    @(posedge i_ref_clk) disable iff (!i_rst_n || !i_ce)
    pin_rst |=> o_ctrl.a_law && o_ctrl.chop_clk == 2'h3 &&
      o_ctrl.ch_en == 4'h0 && o_tx_slot[3] == 8'h03;
  endproperty
  a_rst_defaults: assert property (p_rst_defaults) else $error("dflt"); // R17
  property p_done_stay;
    @(posedge i_ref_clk) disable iff (!i_rst_n || !i_ce)
    (q.st == qcmp_pkg::QCMP_DONE && !cs_n && !pin_rst) |=>
      q.st == qcmp_pkg::QCMP_DONE;
  endproperty
  a_done_stay: assert property (p_done_stay) else $error("done"); // R26
  property p_tx_hold;
    @(posedge i_ref_clk) disable iff (!i_rst_n || !i_ce)
    (o_tx_valid && !i_tx_ready && !pin_rst && !soft_rst) |=>
      o_tx_valid && $stable(o_tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx drop"); // R6
  property p_reg_down;
    @(posedge i_ref_clk) disable iff (!i_rst_n || !i_ce)
    (q.st == qcmp_pkg::QCMP_DATA && !q.rd && q.ct != `QCMP_CT_RAM &&
     byte_in && !pin_rst) |=> q.addr == $past(q.addr) - 5'h01;
  endproperty
  a_reg_down: assert property (p_reg_down) else $error("addr"); // R2
endmodule

/* File: dv/qcmp_host.sv */
/*
  Host processor model on the far side of the command port: frames
  bytes with chip select and accepts read bytes, promptly or slowly.
  Assumes the same clock as the port and whole bytes on both sides.
*/
`timescale 1ns/1ps
module qcmp_host (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_tx_valid,
  input  wire logic [7:0]           i_tx_data,
  output logic                      o_cs_n,
  output qcmp_pkg::qcmp_byte_t      o_rx,
  output logic                      o_tx_ready
);
  initial begin
    o_cs_n     = 1'b1;
    o_rx       = '0;
    o_tx_ready = 1'b0;
  end

  // ----------------------------------------
  // Framing
  // ----------------------------------------
  // Three edges cover the chip select synchroniser before byte one
  task start_frame;
    @(posedge i_ref_clk);
    o_cs_n <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
  endtask

  task end_frame;
    @(posedge i_ref_clk);
    o_cs_n <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
  endtask

  // ----------------------------------------
  // Byte transfer
  // ----------------------------------------
  // Idle data is inverted so a stale byte never reads as fresh
  task put(input logic [7:0] v);
    @(posedge i_ref_clk);
    o_rx <= '{valid: 1'b1, data: v};
    @(posedge i_ref_clk);
    o_rx <= '{valid: 1'b0, data: ~v};
    @(posedge i_ref_clk);
  endtask

  task get(input int stall, output logic [7:0] v);
    int n;
    v = 8'hxx;
    n = 0;
    while (n < 64) begin
      @(posedge i_ref_clk);
      if (i_tx_valid === 1'b1) break;
      n++;
    end
    if (n < 64) begin
      repeat (stall) @(posedge i_ref_clk);
      o_tx_ready <= 1'b1;
      @(posedge i_ref_clk);
      v = i_tx_data;
      o_tx_ready <= 1'b0;
    end
  endtask
endmodule

/* File: dv/qcmp_cmd_port_bench.sv */
/*
  Self-checking bench of the command port: defaults, register and
  coefficient RAM traffic, abort and resets.
  Assumes qcmp_map.svh on the include path and the host model.
*/
`timescale 1ns/1ps
module qcmp_cmd_port_bench;
  localparam logic [7:0] ID = 8'h3C; // Arbitrary value
  localparam qcmp_pkg::qcmp_ctrl_t CDEF = '{ch_en: 4'h0, clk_sel: 4'h2,
    a_law: 1'b1, power_up: 4'h0, loop_en: 1'b0, sb_dir_out: 4'h0,
    debounce_en: 1'b0, irq_en: 1'b0, features_en: 1'b0,
    chop_clk: 2'h3, filters_en: 1'b0, hpf_en: 1'b1};
  logic                 clk, rst_n, pin_n, cs_n, rdy, tx_v, txp, rxp;
  logic [7:0]           tx_d, b;
  qcmp_pkg::qcmp_byte_t rx;
  qcmp_pkg::qcmp_ctrl_t ctrl;
  logic [7:0]           ts [4], rs [4], cf [4], li [4];
  logic [7:0]           p1 [$], p3 [$], p5 [$];
  int                   n_fail, tests_run;

  qcmp_cmd_port #(.RST_MIN_CYC(4), .ID_CODE(ID)) DUT (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1),
    .i_pin_reset_n(pin_n), .i_cs_n(cs_n), .i_rx(rx), .i_tx_ready(rdy),
    .o_tx_valid(tx_v), .o_tx_data(tx_d), .o_ctrl(ctrl), .o_tx_slot(ts),
    .o_rx_slot(rs), .o_coef_sel(cf), .o_loop_irq(li),
    .o_tx_pin_one_sel(txp), .o_rx_pin_one_sel(rxp), .o_int_clear());
  qcmp_host host (.i_ref_clk(clk), .i_tx_valid(tx_v), .i_tx_data(tx_d),
    .o_cs_n(cs_n), .o_rx(rx), .o_tx_ready(rdy));

  // ----------------------------------------
  // Shared checks and transfers
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task rd(input string nm, input logic [7:0] e, input int st);
    host.get(st, b);
    chk(nm, {24'h0, e}, {24'h0, b});
  endtask

  task frame(input logic [7:0] q [$]);
    host.start_frame();
    foreach (q[k]) host.put(q[k]);
    host.end_frame();
  endtask

  // Low two bits of each word carry nothing, so they read as zero
  task ram_rd(input logic [7:0] cmd, input logic [7:0] e [$]);
    host.start_frame();
    host.put(cmd);
    rd("ident", ID, 0);
    foreach (e[k]) rd("ram", k % 2 ? e[k] & 8'hFC : e[k], k % 3);
    host.end_frame();
  endtask

  task defaults;
    chk("ctrl", CDEF, ctrl);
    chk("pin_sel", 2'b11, {txp, rxp});
    for (int i = 0; i < 4; i++) begin
      chk("tx_slot", i, ts[i]);
      chk("rx_slot", i, rs[i]);
      chk("coef_sel", 8'h08, cf[i]);
      chk("loop_irq", 0, li[i]);
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_local;
    frame('{8'hA5, 8'h12});
    chk("ch_en", 4'h1, ctrl.ch_en);
    frame('{8'h81, 8'h66, 8'h3B, 8'hC4});
    chk("loop_irq0", 8'h66, li[0]);
    chk("coef_sel0", 8'h3B, cf[0]);
    chk("coef_sel1", 8'h08, cf[1]);
    host.start_frame();
    host.put(8'h01);
    rd("ident", ID, 0);
    rd("loop_irq", 8'h66, 2);
    rd("coef_sel", 8'h3B, 0);
    host.end_frame();
    $display("test local done");
  endtask

  task t_global;
    frame('{8'hA0, 8'hFF});
    host.start_frame();
    host.put(8'h20);
    rd("ident", ID, 1);
    rd("version", 8'h01, 0);
    host.end_frame();
    $display("test global done");
  endtask

  task t_ram;
    for (int k = 0; k < 16; k++) begin
      p1.push_back({k[3:0], ~k[3:0]});
      p3.push_back({~k[3:0], k[3:0]});
      if (k < 8) p5.push_back(8'hE7);
    end
    frame({8'hE0, p1});
    ram_rd(8'h60, p1);
    frame({8'hE2, p3});
    frame({8'hE2, p5, 8'hE7});
    ram_rd(8'h62, {p5, p3[8:15]});
    ram_rd(8'h60, p1);
    $display("test ram done");
  endtask

  task t_reset;
    @(posedge clk);
    pin_n <= 1'b0;
    repeat (12) @(posedge clk);
    pin_n <= 1'b1;
    repeat (6) @(posedge clk);
    defaults();
    ram_rd(8'h60, p1);
    frame('{8'hA5, 8'h12, 8'hA0});
    chk("ch_en", 4'h1, ctrl.ch_en);
    frame('{8'hA2});
    defaults();
    ram_rd(8'h62, {p5, p3[8:15]});
    $display("test reset done");
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Whole run is under a thousand cycles; the limit leaves ample slack
  initial begin
    #(25 * 60000);
    n_fail++;
    give_verdict();
  end

  initial begin
    n_fail = 0;
    tests_run = 0;
    rst_n = 1'b0;
    pin_n = 1'b1;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    defaults();
    $display("test defaults done");
    t_local();
    t_global();
    t_ram();
    t_reset();
    give_verdict();
  end
endmodule
